// ==== hw/trigger_shutter_pkg.sv ====
// Constants, register map and carrier types for the trigger shutter sequencer.
// Assumes a 250 MHz pclk; every time below is turned into a cycle count here.
package trigger_shutter_pkg;

   // ----------------------------------------------------------------
   // Clock and timing figures
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ           = 250_000_000;
   localparam int unsigned EXTEND_525_US      = 97;
   localparam int unsigned EXTEND_625_US      = 120;
   localparam int unsigned EXTEND_525_CYCLES  = EXTEND_525_US * (CLOCK_HZ / 1_000_000);
   localparam int unsigned EXTEND_625_CYCLES  = EXTEND_625_US * (CLOCK_HZ / 1_000_000);
   localparam int unsigned LONG_PULSE_DIV     = 3;
   localparam int unsigned LONG_PULSE_CYCLES  = (CLOCK_HZ + LONG_PULSE_DIV - 1) / LONG_PULSE_DIV;
   localparam int unsigned INHIBIT_MS         = 50;
   localparam int unsigned INHIBIT_CYCLES     = INHIBIT_MS * (CLOCK_HZ / 1000);
   localparam int unsigned LINE_HZ_525        = 15734;
   localparam int unsigned LINE_HZ_625        = 15625;
   localparam int unsigned HALF_LINE_525      = (CLOCK_HZ / LINE_HZ_525) / 2;
   localparam int unsigned HALF_LINE_625      = (CLOCK_HZ / LINE_HZ_625) / 2;
   localparam logic [9:0]  HALF_LINES_525     = 10'd525;
   localparam logic [9:0]  HALF_LINES_625     = 10'd625;
   localparam logic [1:0]  VD_LINE_STARTS     = 2'd2;
   localparam logic [1:0]  SWITCH_LINE_STARTS = 2'd1;
   localparam logic [2:0]  DRIVE_LOSS_HALVES  = 3'd4;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  CONTROL_OFFSET = 8'h00;
   localparam logic [7:0]  SHUTTER_OFFSET = 8'h04;
   localparam logic [7:0]  STATUS_OFFSET  = 8'h08;
   localparam logic [7:0]  WIDTH_OFFSET   = 8'h0c;
   localparam logic [4:0]  CONTROL_RESET  = 5'h01;
   localparam logic [31:0] SHUTTER_RESET  = 32'h0003_d090;

   typedef struct packed {
      logic field_accumulate;
      logic external_sync_select;
      logic line_625;
      logic switch_exposure;
      logic trigger_enable;
   } control_type;

   typedef struct packed {
      logic [6:0] state;
      logic       inhibit;
      logic       interlaced;
      logic       drives_present;
      logic       external_active;
      logic       trigger_level;
   } status_type;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_EXPOSE  = 7'b0000010,
      ST_WAIT    = 7'b0000100,
      ST_READOUT = 7'b0001000,
      ST_NORMAL  = 7'b0010000,
      ST_INHIBIT = 7'b0100000,
      ST_FREE    = 7'b1000000
   } seq_state_type;

endpackage

// ==== hw/sync_two_stage.sv ====
// Two flip-flop synchroniser for one pin.
// Assumes the pin is asynchronous to pclk; only stage two is for use.
`timescale 1ns/10ps
module sync_two_stage (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic pin,
   output logic      level
);
   logic stage_one;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_one <= 1'b0;
         level     <= 1'b0;
      end else if (ce) begin
         stage_one <= pin;
         level     <= stage_one;
      end
   end
endmodule

// ==== hw/trigger_shutter_sequencer.sv ====
// Exposure and frame start sequencer for external trigger shutter mode.
// Assumes an APB master on pclk and trigger and drive pins from a host.
//
// Behaviour
// R1 - Host spaces pulse triggers width+field+2H.
// R2 - Host spaces switch triggers shutter+field+2H.
// R3 - Bad triggers ignored; recovers within fields.
// R4 - 525-line exposure is width plus 97 us.
// R5 - 625-line exposure is width plus 120 us.
// R6 - Host pulse width 2 us to 1/4 s.
// R7 - Pulse of 1/3 s forces normal operation.
// R8 - Falling edge restores trigger shutter operation.
// R9 - Host sends no trigger 50 ms after.
// R10 - Vertical drive 1H to 2H after fall.
// R11 - One frame-valid pulse entering normal operation.
// R12 - Switch mode uses shutter setting, ignores width.
// R13 - Switch mode outputs image at earliest point.
// R14 - External select auto-picks sync by drive presence.
// R15 - Interlace follows the incoming sync automatically.
// R16 - Frame or field accumulation is selectable.
// R17 - Every output image has its frame-valid pulse; fields transferred in normal operation get none.
// R18 - Pulse width measured in pclk cycles.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
module trigger_shutter_sequencer
   import trigger_shutter_pkg::*;
#(
   parameter logic [31:0] LONG_PULSE  = 32'(LONG_PULSE_CYCLES),
   parameter logic [31:0] INHIBIT     = 32'(INHIBIT_CYCLES),
   parameter logic [31:0] EXTEND_525  = 32'(EXTEND_525_CYCLES),
   parameter logic [31:0] EXTEND_625  = 32'(EXTEND_625_CYCLES),
   parameter logic [31:0] HALF_525    = 32'(HALF_LINE_525),
   parameter logic [31:0] HALF_625    = 32'(HALF_LINE_625)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        trigger_pin,
   input  wire logic        horizontal_drive_in,
   input  wire logic        vertical_drive_in,
   output logic             horizontal_drive,
   output logic             vertical_drive,
   output logic             frame_valid,
   output logic             exposure_active,
   output logic             sensor_transfer,
   output logic             sync_external
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic trig_s;
   logic hd_s;
   logic vd_s;
   logic trig_d;
   logic hd_d;
   logic vd_d;

   sync_two_stage sync_trig (.pclk(pclk), .presetn(presetn), .ce(ce),
                             .pin(trigger_pin), .level(trig_s));
   sync_two_stage sync_hd   (.pclk(pclk), .presetn(presetn), .ce(ce),
                             .pin(horizontal_drive_in), .level(hd_s));
   sync_two_stage sync_vd   (.pclk(pclk), .presetn(presetn), .ce(ce),
                             .pin(vertical_drive_in), .level(vd_s));

   wire trig_rise = trig_s & ~trig_d;
   wire trig_fall = ~trig_s & trig_d;
   wire hd_fall   = ~hd_s & hd_d;
   wire vd_fall   = ~vd_s & vd_d;

   // ----------------------------------------------------------------
   // Registers and APB decode
   // ----------------------------------------------------------------
   control_type   control;
   logic [31:0]   shutter;
   logic [31:0]   width_count;
   logic [31:0]   last_width;
   seq_state_type state;
   status_type    status;
   logic          interlaced;
   logic          drives_present;

   wire        access     = psel & penable;
   wire        mapped     = (paddr[31:8] == 24'h00_0000) & (paddr[1:0] == 2'b00) &
                            (paddr[7:4] == 4'h0);
   wire        commit     = access & pready & mapped;
   wire        write_ctl  = commit & pwrite & (paddr[7:0] == CONTROL_OFFSET);
   wire        write_shut = commit & pwrite & (paddr[7:0] == SHUTTER_OFFSET);
   wire [31:0] read_mux   = (paddr[7:0] == CONTROL_OFFSET) ? {27'h0, control} :
                            (paddr[7:0] == SHUTTER_OFFSET) ? shutter :
                            (paddr[7:0] == STATUS_OFFSET)  ? {20'h0, status} :
                            last_width;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         prdata  <= (access & ~pready & ~pwrite & mapped) ? read_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= control_type'(CONTROL_RESET);
         shutter <= SHUTTER_RESET;
      end else if (ce) begin
         if (write_ctl) begin
            control <= control_type'(pwdata[4:0]);
         end
         if (write_shut) begin
            shutter <= pwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sync source and line timing
   // ----------------------------------------------------------------
   logic [31:0] half_count;
   logic [9:0]  half_lines;
   logic [2:0]  loss_halves;
   logic        line_phase;
   logic        phase_at_vd;
   logic        force_vd;

   wire [31:0] half_len    = control.line_625 ? HALF_625 : HALF_525;
   wire [9:0]  field_len   = control.line_625 ? HALF_LINES_625 : HALF_LINES_525;
   wire        use_ext     = control.external_sync_select & drives_present; // R14
   // A length change can leave a count past its new end, so ends compare with >=.
   wire        half_due    = (half_count >= half_len - 32'd1);
   wire        half_end    = half_due | (use_ext & hd_fall);
   wire        line_start  = half_end & line_phase;
   wire        field_end   = use_ext ? vd_fall
                                     : half_end & (half_lines >= field_len - 10'd1);
   wire        vd_event    = force_vd | field_end;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_count     <= 32'h0000_0000;
         half_lines     <= 10'h000;
         line_phase     <= 1'b0;
         loss_halves    <= 3'h0;
         drives_present <= 1'b0;
         phase_at_vd    <= 1'b0;
         interlaced     <= 1'b0;
      end else if (ce) begin
         half_count <= half_end ? 32'h0000_0000 : half_count + 32'd1;
         if (use_ext & hd_fall) begin
            line_phase <= 1'b1;
         end else if (half_end) begin
            line_phase <= ~line_phase;
         end
         if (vd_event) begin
            half_lines <= 10'h000;
         end else if (half_end) begin
            half_lines <= half_lines + 10'd1;
         end
         // A lost drive is noticed after five silent half lines, then timing free-runs.
         if (hd_fall) begin
            loss_halves    <= 3'h0;
            drives_present <= 1'b1;
         end else if (half_due) begin
            loss_halves    <= (loss_halves == DRIVE_LOSS_HALVES) ? loss_halves
                                                                 : loss_halves + 3'd1;
            drives_present <= (loss_halves != DRIVE_LOSS_HALVES);
         end
         if (use_ext & vd_fall) begin
            phase_at_vd <= (half_count > (half_len >> 1)); // R15
            interlaced  <= (half_count > (half_len >> 1)) != phase_at_vd; // R15
         end
      end
   end

   // ----------------------------------------------------------------
   // Trigger sequencer
   // ----------------------------------------------------------------
   logic [31:0] run_count;
   logic [31:0] extend_count;
   logic [1:0]  lines_seen;
   logic        odd_field;

   wire long_pulse = trig_s & (width_count >= LONG_PULSE);
   wire [31:0] extend_len = control.line_625 ? EXTEND_625 : EXTEND_525;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_FREE;
         trig_d       <= 1'b0;
         hd_d         <= 1'b0;
         vd_d         <= 1'b0;
         width_count  <= 32'h0000_0000;
         last_width   <= 32'h0000_0000;
         run_count    <= 32'h0000_0000;
         extend_count <= 32'h0000_0000;
         lines_seen   <= 2'b00;
         force_vd     <= 1'b0;
      end else if (ce) begin
         trig_d   <= trig_s;
         hd_d     <= hd_s;
         vd_d     <= vd_s;
         force_vd <= 1'b0;
         // Width counts in pclk cycles and saturates rather than wraps.
         if (trig_rise) begin
            width_count <= 32'h0000_0001; // R18
         end else if (trig_s & (width_count != 32'hffff_ffff)) begin
            width_count <= width_count + 32'd1; // R18
         end
         if (trig_fall) begin
            last_width <= width_count;
         end
         if (trig_fall & (state == ST_EXPOSE) & ~control.switch_exposure) begin
            extend_count <= extend_len; // R4 R5
         end else if (extend_count != 32'h0000_0000) begin
            extend_count <= extend_count - 32'd1;
         end
         if (line_start & (lines_seen != 2'b11)) begin
            lines_seen <= lines_seen + 2'd1;
         end
         if (!control.trigger_enable) begin
            state <= ST_FREE;
         end else if (long_pulse & (state != ST_NORMAL) & (state != ST_INHIBIT)) begin
            state <= ST_NORMAL; // R7
         end else begin
            unique case (state)
               ST_FREE, ST_IDLE: begin
                  // Triggers in a busy state are dropped, so bad spacing heals. R3
                  if (trig_rise) begin
                     state     <= ST_EXPOSE;
                     run_count <= shutter;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
               ST_EXPOSE: begin
                  run_count <= run_count - 32'd1;
                  if (control.switch_exposure & (run_count <= 32'd1)) begin
                     state      <= ST_WAIT; // R12
                     lines_seen <= 2'b00;
                  end else if (~control.switch_exposure & trig_fall) begin
                     state      <= ST_WAIT;
                     lines_seen <= 2'b00;
                  end
               end
               ST_WAIT: begin
                  if (line_start & (lines_seen + 2'd1 ==
                      (control.switch_exposure ? SWITCH_LINE_STARTS : VD_LINE_STARTS))) begin
                     state    <= ST_READOUT; // R10 R13
                     force_vd <= 1'b1;
                  end
               end
               ST_READOUT: begin
                  if (field_end) begin
                     state <= ST_IDLE;
                  end
               end
               ST_NORMAL: begin
                  if (trig_fall) begin
                     state     <= ST_INHIBIT; // R8
                     run_count <= INHIBIT;
                  end
               end
               ST_INHIBIT: begin
                  // Inhibit window ignores triggers; host honours it anyway. R9
                  run_count <= run_count - 32'd1;
                  if (run_count <= 32'd1) begin
                     state <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   wire enter_normal = control.trigger_enable & long_pulse &
                       (state != ST_NORMAL) & (state != ST_INHIBIT);
   wire free_running = (state == ST_FREE) | (state == ST_NORMAL);
   wire transfer_now = force_vd |
                       (field_end & free_running & (control.field_accumulate | odd_field));

   assign status = '{state: state, inhibit: (state == ST_INHIBIT), interlaced: interlaced,
                     drives_present: drives_present, external_active: use_ext,
                     trigger_level: trig_s};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         horizontal_drive <= 1'b0;
         vertical_drive   <= 1'b0;
         frame_valid      <= 1'b0;
         exposure_active  <= 1'b0;
         sensor_transfer  <= 1'b0;
         sync_external    <= 1'b0;
         odd_field        <= 1'b0;
      end else if (ce) begin
         horizontal_drive <= line_start;
         vertical_drive   <= vd_event; // R10
         // One pulse per triggered image, one per free field, one on entry. R11 R17
         frame_valid      <= force_vd | enter_normal | (field_end & (state == ST_FREE));
         exposure_active  <= ((state == ST_EXPOSE) & ~enter_normal) |
                             (extend_count > 32'd1); // R4 R5
         sensor_transfer  <= transfer_now; // R16
         sync_external    <= use_ext; // R14
         if (vd_event) begin
            odd_field <= ~odd_field;
         end
      end
   end

endmodule

// ==== bench/trigger_shutter_chk.sv ====
// Port assertions for the trigger shutter sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/10ps
module trigger_shutter_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        trigger_pin,
   input wire logic        horizontal_drive_in,
   input wire logic        vertical_drive_in,
   input wire logic        horizontal_drive,
   input wire logic        vertical_drive,
   input wire logic        frame_valid,
   input wire logic        exposure_active,
   input wire logic        sensor_transfer,
   input wire logic        sync_external
);
   // ---------------------------------------------------------------
   // Helper logic and assertions
   // ---------------------------------------------------------------
   localparam int VD_MAX = 400;
   logic [9:0] quiet;
   // Saturating idle count; its end lies far beyond the loss window.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 10'h000;
      end else if ($changed(horizontal_drive_in) || $changed(vertical_drive_in)) begin
         quiet <= 10'h000;
      end else if (quiet != 10'h3ff) begin
         quiet <= quiet + 10'h001;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ($rose(psel && penable) |=> pready)
      else $error("pready missing in second access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   a_idle_data: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   a_valid_single: assert property (frame_valid |=> !frame_valid)
      else $error("frame valid longer than one cycle");
   a_vd_single: assert property (vertical_drive |=> !vertical_drive)
      else $error("vertical drive longer than one cycle");
   a_hd_single: assert property (horizontal_drive |=> !horizontal_drive)
      else $error("line drive longer than one cycle");
   a_xfer_single: assert property (sensor_transfer |=> !sensor_transfer)
      else $error("transfer longer than one cycle");
   a_vd_after_exp: assert property ($fell(exposure_active) && !trigger_pin |-> ##[1:VD_MAX] vertical_drive)
      else $error("no vertical drive after exposure");
   a_int_sync: assert property (quiet == 10'h3ff |-> !sync_external)
      else $error("external sync kept without drives");
   c_frame: cover property (frame_valid);
   c_error: cover property (pslverr);
   c_expose: cover property ($fell(exposure_active) && !trigger_pin);
endmodule

bind trigger_shutter_sequencer trigger_shutter_chk u_trigger_shutter_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
   .horizontal_drive_in(horizontal_drive_in), .vertical_drive_in(vertical_drive_in),
   .horizontal_drive(horizontal_drive), .vertical_drive(vertical_drive),
   .frame_valid(frame_valid), .exposure_active(exposure_active),
   .sensor_transfer(sensor_transfer), .sync_external(sync_external)
);

// ==== bench/host_trigger_model.sv ====
// Host model: trigger pulses of commanded width, optional line and field drives.
// Assumes the bench commands it on pclk and keeps the spacing between triggers.
`timescale 1ns/10ps
module host_trigger_model #(
   parameter int LINE  = 80,
   parameter int FIELD = 262
) (
   input  wire logic        pclk,
   input  wire logic        fire,
   input  wire logic [31:0] width,
   input  wire logic        drives_on,
   output logic             busy,
   output logic             trigger_pin,
   output logic             horizontal_drive_in,
   output logic             vertical_drive_in
);
   // ---------------------------------------------------------------
   // Trigger and drives
   // ---------------------------------------------------------------
   logic [31:0] left = 32'h0;
   int          hcnt = 0;
   int          lcnt = 0;
   initial begin
      busy                = 1'b0;
      trigger_pin         = 1'b0;
      horizontal_drive_in = 1'b1;
      vertical_drive_in   = 1'b1;
   end
   // The pulse lasts exactly width cycles, so the bench controls it to the cycle.
   always @(posedge pclk) begin
      if (fire && !busy) begin
         trigger_pin <= 1'b1;
         busy        <= 1'b1;
         left        <= width;
      end else if (left > 32'h1) begin
         left <= left - 32'h1;
      end else begin
         trigger_pin <= 1'b0;
         busy        <= 1'b0;
      end
   end
   // Drives hold their idle high level while the host sends no sync.
   always @(posedge pclk) begin
      hcnt <= (hcnt >= LINE - 1) ? 0 : hcnt + 1;
      if (hcnt == LINE - 1) begin
         lcnt <= (lcnt >= FIELD - 1) ? 0 : lcnt + 1;
      end
      horizontal_drive_in <= !(drives_on && hcnt < 8);
      vertical_drive_in   <= !(drives_on && lcnt == 0);
   end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the trigger shutter sequencer.
// Assumes the host model, the bound checker and shortened timing parameters.
`timescale 1ns/10ps
module testbench
   import trigger_shutter_pkg::*;
;
   // ---------------------------------------------------------------
   // Design, host and helpers
   // ---------------------------------------------------------------
   localparam int E5 = 50, E6 = 60, H5 = 40, H6 = 45;
   typedef struct {logic wr; logic [31:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_type;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [31:0] paddr, pwdata, prdata, width, q;
   logic        trigger_pin, hd_in, vd_in, fire, drives_on, busy;
   logic        horizontal_drive, vertical_drive, frame_valid;
   logic        exposure_active, sensor_transfer, sync_external;
   int          n_fail, checks_done, cyc, fv_n, ex_n, dur, vf, ve, tr, f0;
   row_type     rows [8] = '{
      '{1'b0, 32'h00, 32'h0, 32'h1, 1'b0}, '{1'b0, 32'h04, 32'h0, 32'h3d090, 1'b0},
      '{1'b1, 32'h100, 32'h1e, 32'h0, 1'b1}, '{1'b0, 32'h00, 32'h0, 32'h1, 1'b0},
      '{1'b1, 32'h0c, 32'hffff, 32'h0, 1'b0}, '{1'b1, 32'h02, 32'hff, 32'h0, 1'b1},
      '{1'b1, 32'h04, 32'h1f4, 32'h1f4, 1'b0}, '{1'b1, 32'h00, 32'h1f, 32'h1f, 1'b0}};
   trigger_shutter_sequencer #(.LONG_PULSE(32'd2000), .INHIBIT(32'd500),
      .EXTEND_525(32'(E5)), .EXTEND_625(32'(E6)), .HALF_525(32'(H5)), .HALF_625(32'(H6)))
   u_trigger_shutter_sequencer (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
      .horizontal_drive_in(hd_in), .vertical_drive_in(vd_in),
      .horizontal_drive(horizontal_drive), .vertical_drive(vertical_drive),
      .frame_valid(frame_valid), .exposure_active(exposure_active),
      .sensor_transfer(sensor_transfer), .sync_external(sync_external));
   host_trigger_model #(.LINE(2 * H5), .FIELD(262)) u_host_trigger_model (.pclk(pclk),
      .fire(fire), .width(width), .drives_on(drives_on), .busy(busy),
      .trigger_pin(trigger_pin), .horizontal_drive_in(hd_in), .vertical_drive_in(vd_in));
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc  <= cyc + 1;
      fv_n <= fv_n + int'(frame_valid === 1'b1);
      ex_n <= ex_n + int'(exposure_active === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkr(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("wrong value at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic till(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40000) n_fail++;
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      till(pready, 1'b1);
      q       = prdata;
      e       = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_state(input logic [6:0] s);
      int k;
      k = 0;
      do begin
         apb(1'b0, 32'(STATUS_OFFSET), 32'h0);
         k++;
      end while (q[11:5] !== s && k < 12000);
      chk(32'(q[11:5]), 32'(s));
   endtask
   task automatic shot(input logic [31:0] w);
      int t0;
      int t1;
      till(busy, 1'b0);
      fire  <= 1'b1;
      width <= w;
      t0 = cyc;
      @(posedge pclk);
      fire <= 1'b0;
      till(exposure_active, 1'b1);
      tr = cyc - t0;
      till(exposure_active, 1'b0);
      t1  = cyc;
      dur = t1 - t0 - tr;
      till(vertical_drive, 1'b1);
      ve = cyc - t1;
      vf = cyc - t0 - 1 - int'(w);
      chk(32'({frame_valid, sensor_transfer}), 32'h3);
   endtask
   task automatic final_report;
      if (n_fail == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (98000) @(posedge pclk);
      n_fail++;
      final_report();
   end
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      {n_fail, checks_done, cyc, fv_n, ex_n} = '0;
      pclk = 1'b0;
      {presetn, psel, penable, pwrite, fire, drives_on} <= '0;
      {paddr, pwdata, width} <= '0;
      repeat (10) @(posedge pclk);
      chk(32'({frame_valid, vertical_drive, exposure_active, sync_external}), 32'h0);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
         if (rows[i].wr) chk(32'(e), 32'(rows[i].e));
         apb(1'b0, rows[i].a, 32'h0);
         chk(q, rows[i].q);
         chk(32'(e), 32'(rows[i].e));
      end
      apb(1'b1, 32'(CONTROL_OFFSET), 32'h11);
      shot(32'd600);
      chkr(dur, 600 + E5 - 4, 600 + E5 + 4);
      chkr(vf, 2 * H5, 4 * H5 + 8);
      apb(1'b0, 32'(WIDTH_OFFSET), 32'h0);
      chkr(int'(q), 598, 602);
      wait_state(7'h01);
      apb(1'b1, 32'(CONTROL_OFFSET), 32'h15);
      shot(32'd520);
      chkr(dur, 520 + E6 - 4, 520 + E6 + 4);
      chkr(vf, 2 * H6, 4 * H6 + 8);
      wait_state(7'h01);
      apb(1'b1, 32'(CONTROL_OFFSET), 32'h13);
      shot(32'd40);
      chkr(dur, 496, 504);
      chkr(tr, 1, 8);
      chkr(ve, 1, 2 * H5 + 4);
      wait_state(7'h01);
      apb(1'b1, 32'(CONTROL_OFFSET), 32'h11);
      f0 = fv_n;
      fire  <= 1'b1;
      width <= 32'd2600;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (2200) @(posedge pclk);
      apb(1'b0, 32'(STATUS_OFFSET), 32'h0);
      chk(32'(q[11:5]), 32'h10);
      till(trigger_pin, 1'b0);
      repeat (8) @(posedge pclk);
      chk(32'(fv_n - f0), 32'h1);
      apb(1'b0, 32'(STATUS_OFFSET), 32'h0);
      chk(32'(q[11:4]), 32'h41);
      f0 = ex_n;
      fire  <= 1'b1;
      width <= 32'd300;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (310) @(posedge pclk);
      chk(32'(ex_n - f0), 32'h0);
      wait_state(7'h01);
      shot(32'd600);
      chkr(dur, 600 + E5 - 4, 600 + E5 + 4);
      apb(1'b1, 32'(CONTROL_OFFSET), 32'h19);
      drives_on <= 1'b1;
      repeat (2000) @(posedge pclk);
      chk(32'(sync_external), 32'h1);
      apb(1'b0, 32'(STATUS_OFFSET), 32'h0);
      chk(32'(q[2]), 32'h1);
      drives_on <= 1'b0;
      repeat (1500) @(posedge pclk);
      chk(32'(sync_external), 32'h0);
      final_report();
   end
endmodule
